// [logic/ifpc_check.sv]
// Functional notes
// - protected-only opcode in real mode raises vector 6
// - real mode word access at offset ffff raises vector 13
// - real mode flag loads force io_privilege_level and nested_task_flag to zero
// - real mode coprocessor operand past segment limit raises vector 9
// - marked instructions drive bus lock regardless of lock prefix
// - multi-transfer instructions may release bus lock between operand transfers
// - protected mode limit or access fault raises 13, stack limit raises 12
// - segment load checks privilege; not present raises 11, or 12 for stack
// - descriptor table accesses of marked instructions assert bus lock
// - far transfer to other code segment with privilege violation raises 13
// - privileged ops need level 0; io ops fault when level exceeds io level
// - flag pop keeps interrupt enable if level above io level; io level only at 0
// - selector check privilege violation gives no exception, clears zero flag
// - coprocessor escape: start fault 13, stack 12, transfer limit 9
// - control transfer destination beyond code segment limit raises 13
// - direction bit 1 moves result into register operand, 0 from it
// - word size bit 1 is word operation, 0 is byte operation
// - sign extend bit 1 extends immediate byte to 16 bits, 0 takes full word
// - three-component offset calculation costs one extra clock
// - during reset each system clock begins processor phase 2
// - coproc_operand_ack active on first bus operation of operand transfer
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ifpc_check (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_srst,
  input  wire ifpc_pkg::ifpc_wb_req_t i_wb,
  output logic                      o_wb_ack,
  output logic               [31:0] o_wb_dat,
  input  wire ifpc_pkg::ifpc_req_t  i_req,
  output logic                      o_req_ready,
  output ifpc_pkg::ifpc_resp_t      o_resp,
  output ifpc_pkg::ifpc_bus_t       o_bus,
  output logic                      o_bus_lock,
  output logic                      o_coproc_operand_ack,
  output logic                      o_proc_phase2
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ifpc_pkg::ifpc_state_t st;
    ifpc_pkg::ifpc_req_t   held;
    logic                  ready;
    logic                  prot;
    logic [1:0]            current_privilege_level;
    logic [15:0]           flags;
    logic [7:0]            last_vec;
    logic                  fault_seen;
    logic [15:0]           fault_cnt;
    ifpc_pkg::ifpc_resp_t  resp;
    ifpc_pkg::ifpc_bus_t   bus;
    logic                  lock;
    logic                  ack_pe;
    ifpc_pkg::ifpc_phase_t phase;
    logic                  wb_ack;
    logic [31:0]           wb_dat;
  } ifpc_check_state_t;

  ifpc_check_state_t state;
  ifpc_check_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // end of the operand, one bit wider so ffff plus one does not wrap
  function automatic logic over_limit(input logic [15:0] off, input logic word,
                                      input logic [15:0] lim);
    logic [16:0] last;
    last = {1'b0, off} + {16'h0000, word};
    return last > {1'b0, lim};
  endfunction
  // data-segment style rule: effective level is the weaker of current and requested
  function automatic logic priv_bad(input logic [1:0] current_privilege_level, input logic [1:0] requested_privilege_level,
                                    input logic [1:0] descriptor_privilege_level);
    logic [1:0] eff;
    eff = (requested_privilege_level > current_privilege_level) ? requested_privilege_level : current_privilege_level;
    return eff > descriptor_privilege_level;
  endfunction
  function automatic ifpc_pkg::ifpc_fault_t mk(input logic [7:0] v);
    ifpc_pkg::ifpc_fault_t f;
    f.hit = 1'b1;
    f.vec = v;
    return f;
  endfunction
  // memory operand fault, stack segment gets its own vector
  function automatic ifpc_pkg::ifpc_fault_t mem_fault(input ifpc_pkg::ifpc_req_t r);
    ifpc_pkg::ifpc_fault_t f;
    f.hit = 1'b0;
    f.vec = ifpc_pkg::VEC_NONE;
    if (r.stack_seg && over_limit(r.offset, r.word, r.limit)) begin
      f = mk(ifpc_pkg::VEC_STACK);
    end else if (!r.access_ok || over_limit(r.offset, r.word, r.limit)) begin
      f = mk(ifpc_pkg::VEC_GEN_PROT);
    end
    return f;
  endfunction
  function automatic ifpc_pkg::ifpc_fault_t real_fault(input ifpc_pkg::ifpc_req_t r);
    ifpc_pkg::ifpc_fault_t f;
    f.hit = 1'b0;
    f.vec = ifpc_pkg::VEC_NONE;
    if (r.op == ifpc_pkg::OP_PROT_ONLY) begin
      f = mk(ifpc_pkg::VEC_UNDEF_OP);
    end else if (r.op == ifpc_pkg::OP_COPROC_XFER) begin
      if (over_limit(r.offset, r.word, r.limit)) begin
        f = mk(ifpc_pkg::VEC_COPROC_OVR);
      end
    end else if (r.op == ifpc_pkg::OP_FAR_XFER &&
                 (!r.to_code || r.offset > r.limit)) begin
      f = mk(ifpc_pkg::VEC_GEN_PROT);
    end else if (r.mem && r.word && r.offset == ifpc_pkg::WORD_LAST_OFFSET) begin
      f = mk(ifpc_pkg::VEC_GEN_PROT);
    end
    return f;
  endfunction
  function automatic ifpc_pkg::ifpc_fault_t prot_fault(input ifpc_pkg::ifpc_req_t r,
                                                       input logic [1:0] current_privilege_level,
                                                       input logic [1:0] io_privilege_level);
    ifpc_pkg::ifpc_fault_t f;
    f.hit = 1'b0;
    f.vec = ifpc_pkg::VEC_NONE;
    case (r.op)
      ifpc_pkg::OP_PRIV: begin
        if (current_privilege_level != ifpc_pkg::CPL_KERNEL) begin
          f = mk(ifpc_pkg::VEC_GEN_PROT);
        end
      end
      ifpc_pkg::OP_IO: begin
        if (current_privilege_level > io_privilege_level) begin
          f = mk(ifpc_pkg::VEC_GEN_PROT);
        end
      end
      ifpc_pkg::OP_SEG_LOAD: begin
        // stack selector must match the current level exactly
        if (r.dest_ss ? (r.requested_privilege_level != current_privilege_level || r.descriptor_privilege_level != current_privilege_level) : priv_bad(current_privilege_level, r.requested_privilege_level, r.descriptor_privilege_level)) begin
          f = mk(ifpc_pkg::VEC_GEN_PROT);
        end else if (!r.present) begin
          f = mk(r.dest_ss ? ifpc_pkg::VEC_STACK : ifpc_pkg::VEC_NOT_PRESENT);
        end
      end
      ifpc_pkg::OP_FAR_XFER: begin
        if (!r.to_code || r.offset > r.limit) begin
          f = mk(ifpc_pkg::VEC_GEN_PROT);
        end else if (priv_bad(current_privilege_level, r.requested_privilege_level, r.descriptor_privilege_level)) begin
          f = mk(ifpc_pkg::VEC_GEN_PROT);
        end
      end
      ifpc_pkg::OP_COPROC_START: begin
        f = mem_fault(r);
      end
      ifpc_pkg::OP_COPROC_XFER: begin
        if (over_limit(r.offset, r.word, r.limit)) begin
          f = mk(ifpc_pkg::VEC_COPROC_OVR);
        end
      end
      ifpc_pkg::OP_SEL_CHECK: begin
        f.hit = 1'b0;
      end
      default: begin
        if (r.mem) begin
          f = mem_fault(r);
        end
      end
    endcase
    return f;
  endfunction

  // flag image after a flag load; the protection gates depend on mode
  function automatic logic [15:0] load_flags(input logic [15:0] old, input logic [15:0] nw,
                                             input logic prot, input logic [1:0] current_privilege_level);
    logic [15:0] f;
    logic [1:0]  old_io_privilege_level;
    f = nw;
    old_io_privilege_level = old[ifpc_pkg::FLAG_IO_PRIVILEGE_LEVEL_HI:ifpc_pkg::FLAG_IO_PRIVILEGE_LEVEL_LO];
    if (!prot) begin
      f[ifpc_pkg::FLAG_IO_PRIVILEGE_LEVEL_HI:ifpc_pkg::FLAG_IO_PRIVILEGE_LEVEL_LO] = 2'h0;
      f[ifpc_pkg::FLAG_NT] = 1'b0;
    end else begin
      if (current_privilege_level > old_io_privilege_level) begin
        f[ifpc_pkg::FLAG_IF] = old[ifpc_pkg::FLAG_IF];
      end
      if (current_privilege_level != ifpc_pkg::CPL_KERNEL) begin
        f[ifpc_pkg::FLAG_IO_PRIVILEGE_LEVEL_HI:ifpc_pkg::FLAG_IO_PRIVILEGE_LEVEL_LO] = old_io_privilege_level;
      end
    end
    return f;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request selection and operand forming
  ifpc_pkg::ifpc_req_t cur;
  logic                go;
  logic [15:0]         fmt_operand;

  always_comb begin
    if (state.st == ifpc_pkg::ST_EA_EXTRA) begin
      cur = state.held;
      go  = 1'b1;
    end else begin
      cur = i_req;
      // three-part offsets park for one clock first
      go  = i_req.valid && state.ready && !i_req.three_comp;
    end
  end

  ifpc_operand_fmt u_fmt (
    .i_word    (cur.word),
    .i_sext    (cur.sext),
    .i_imm     (cur.imm),
    .o_operand (fmt_operand)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    ifpc_pkg::ifpc_fault_t f;
    logic [31:0]           ctrl_img;
    logic [31:0]           stat_img;
    logic [31:0]           wdat;
    logic                  commit;
    logic                  need_lock;
    logic                  wb_go;
    logic                  hw_fault;

    next_state = state;
    f          = state.prot ? prot_fault(cur, state.current_privilege_level,
                   state.flags[ifpc_pkg::FLAG_IO_PRIVILEGE_LEVEL_HI:ifpc_pkg::FLAG_IO_PRIVILEGE_LEVEL_LO])
                            : real_fault(cur);
    commit     = go && !f.hit;
    hw_fault   = go && f.hit;
    ctrl_img   = {29'h0000_0000, state.current_privilege_level, state.prot};
    stat_img   = {23'h00_0000, state.fault_seen, state.last_vec};
    wdat       = ifpc_pkg::DAT_ZERO;
    wb_go      = i_wb.cyc && i_wb.stb && !state.wb_ack;

    // phase follows the system clock; reset keeps restarting phase 2
    next_state.phase = (state.phase == ifpc_pkg::PH2) ? ifpc_pkg::PH1 : ifpc_pkg::PH2;

    // sequencing
    if (state.st == ifpc_pkg::ST_EA_EXTRA) begin
      next_state.st = ifpc_pkg::ST_IDLE;
    end else if (i_req.valid && state.ready && i_req.three_comp) begin
      next_state.st   = ifpc_pkg::ST_EA_EXTRA;
      next_state.held = i_req;
    end
    next_state.ready = (next_state.st == ifpc_pkg::ST_IDLE);

    // response; a fault carries its vector and the current zero flag, no operand or result
    next_state.resp.valid   = go;
    next_state.resp.fault   = hw_fault;
    next_state.resp.vector  = hw_fault ? f.vec : ifpc_pkg::VEC_NONE;
    next_state.resp.operand = commit ? fmt_operand : 16'h0000;
    next_state.resp.to_reg  = commit && cur.dir;
    next_state.resp.word    = commit && cur.word;
    next_state.resp.zf      = state.flags[ifpc_pkg::FLAG_ZF];

    if (commit && cur.op == ifpc_pkg::OP_FLAG_LOAD) begin
      next_state.flags = load_flags(state.flags, cur.flags_in, state.prot, state.current_privilege_level);
    end
    if (commit && cur.op == ifpc_pkg::OP_SEL_CHECK) begin
      // a bad selector answers with zero flag low and no result
      next_state.flags[ifpc_pkg::FLAG_ZF] = !priv_bad(state.current_privilege_level, cur.requested_privilege_level, cur.descriptor_privilege_level);
      next_state.resp.zf = !priv_bad(state.current_privilege_level, cur.requested_privilege_level, cur.descriptor_privilege_level);
      if (priv_bad(state.current_privilege_level, cur.requested_privilege_level, cur.descriptor_privilege_level)) begin
        next_state.resp.operand = 16'h0000;
        next_state.resp.to_reg  = 1'b0;
      end
    end

    // lock is held for one transfer only, so repeated ops drop it between items
    need_lock = cur.lock_prefix || cur.op == ifpc_pkg::OP_LOCKED;
    need_lock = need_lock || (state.prot && cur.desc_access);
    next_state.lock = go && need_lock;

    // bus operation that carries the operand
    next_state.bus.valid = commit && (cur.mem || cur.op == ifpc_pkg::OP_COPROC_XFER);
    next_state.bus.is_io = commit && cur.op == ifpc_pkg::OP_COPROC_XFER && cur.xfer_io;
    next_state.bus.addr  = (commit && cur.op == ifpc_pkg::OP_COPROC_XFER && cur.xfer_io)
                           ? ifpc_pkg::COPROC_PORT : cur.offset;
    next_state.ack_pe    = commit && cur.op == ifpc_pkg::OP_COPROC_XFER && cur.first;

    // status
    if (hw_fault) begin
      next_state.last_vec  = f.vec;
      next_state.fault_cnt = state.fault_cnt + ifpc_pkg::CNT_ONE;
    end

    // register slave: answer one clock after the strobe, drop ack the next
    next_state.wb_ack = wb_go;
    next_state.wb_dat = ifpc_pkg::DAT_ZERO;
    if (wb_go && !i_wb.we) begin
      if (i_wb.adr == ifpc_pkg::REG_CTRL) begin
        next_state.wb_dat = ctrl_img;
      end else if (i_wb.adr == ifpc_pkg::REG_STATUS) begin
        next_state.wb_dat = stat_img;
      end else if (i_wb.adr == ifpc_pkg::REG_FLAGS) begin
        next_state.wb_dat = {16'h0000, state.flags};
      end else if (i_wb.adr == ifpc_pkg::REG_FAULTS) begin
        next_state.wb_dat = {16'h0000, state.fault_cnt};
      end else begin
        next_state.wb_dat = ifpc_pkg::DAT_ZERO;
      end
    end
    if (wb_go && i_wb.we) begin
      if (i_wb.adr == ifpc_pkg::REG_CTRL) begin
        wdat = merge(ctrl_img, i_wb.dat, i_wb.sel);
        next_state.prot = wdat[ifpc_pkg::CTRL_PROT_BIT];
        next_state.current_privilege_level  = wdat[ifpc_pkg::CTRL_CPL_HI:ifpc_pkg::CTRL_CPL_LO];
      end else if (i_wb.adr == ifpc_pkg::REG_STATUS) begin
        if (i_wb.sel[1] && i_wb.dat[ifpc_pkg::STAT_SEEN_BIT]) begin
          next_state.fault_seen = 1'b0;
        end
      end else if (i_wb.adr == ifpc_pkg::REG_FLAGS) begin
        // an instruction committing flags in the same clock wins
        if (!(commit && (cur.op == ifpc_pkg::OP_FLAG_LOAD ||
                         cur.op == ifpc_pkg::OP_SEL_CHECK))) begin
          wdat = merge({16'h0000, state.flags}, i_wb.dat, i_wb.sel);
          next_state.flags = wdat[15:0];
        end
      end
    end
    // sticky fault flag: a new fault beats the software clear
    if (hw_fault) begin
      next_state.fault_seen = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state            <= '0;
      state.ready      <= 1'b1;
      state.flags      <= ifpc_pkg::FLAGS_RST;
      state.phase      <= ifpc_pkg::PH2;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    o_wb_ack             = state.wb_ack;
    o_wb_dat             = state.wb_dat;
    o_req_ready          = state.ready;
    o_resp               = state.resp;
    o_bus                = state.bus;
    o_bus_lock           = state.lock;
    o_coproc_operand_ack = state.ack_pe;
    o_proc_phase2        = (state.phase == ifpc_pkg::PH2);
  end

endmodule // ifpc_check
`default_nettype wire

// [logic/ifpc_operand_fmt.sv]
`timescale 1ns/1ps
`default_nettype none
module ifpc_operand_fmt (
  input  wire logic        i_word,
  input  wire logic        i_sext,
  input  wire logic [15:0] i_imm,
  output logic      [15:0] o_operand
);

  always_comb begin
    if (!i_word) begin
      o_operand = {8'h00, i_imm[7:0]};
    end else if (i_sext) begin
      o_operand = {{8{i_imm[7]}}, i_imm[7:0]};
    end else begin
      o_operand = i_imm;
    end
  end

endmodule // ifpc_operand_fmt
`default_nettype wire

// [logic/ifpc_pkg.sv]
`default_nettype none
package ifpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // exception vectors
  localparam logic [7:0] VEC_NONE        = 8'h00;
  localparam logic [7:0] VEC_UNDEF_OP    = 8'h06;
  localparam logic [7:0] VEC_COPROC_OVR  = 8'h09;
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0b;
  localparam logic [7:0] VEC_STACK       = 8'h0c;
  localparam logic [7:0] VEC_GEN_PROT    = 8'h0d;

  localparam logic [15:0] WORD_LAST_OFFSET = 16'hffff;
  localparam logic [15:0] COPROC_PORT      = 16'h00fa;
  localparam logic [1:0]  CPL_KERNEL       = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // flag word layout
  localparam int FLAG_ZF      = 6;
  localparam int FLAG_IF      = 9;
  localparam int FLAG_IO_PRIVILEGE_LEVEL_LO = 12;
  localparam int FLAG_IO_PRIVILEGE_LEVEL_HI = 13;
  localparam int FLAG_NT      = 14;
  localparam logic [15:0] FLAGS_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] REG_FLAGS  = 8'h08;
  localparam logic [ADR_W-1:0] REG_FAULTS = 8'h0c;
  localparam int CTRL_PROT_BIT   = 0;
  localparam int CTRL_CPL_LO     = 1;
  localparam int CTRL_CPL_HI     = 2;
  localparam int STAT_SEEN_BIT   = 8;
  localparam logic [31:0] DAT_ZERO = 32'h0000_0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    OP_PLAIN        = 4'h0,
    OP_PROT_ONLY    = 4'h1,
    OP_PRIV         = 4'h2,
    OP_IO           = 4'h3,
    OP_SEG_LOAD     = 4'h4,
    OP_SEL_CHECK    = 4'h5,
    OP_FAR_XFER     = 4'h6,
    OP_FLAG_LOAD    = 4'h7,
    OP_COPROC_START = 4'h8,
    OP_COPROC_XFER  = 4'h9,
    OP_LOCKED       = 4'ha,
    OP_STRING       = 4'hb
  } ifpc_op_t;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_EA_EXTRA = 2'b01
  } ifpc_state_t;

  typedef enum logic {
    PH1 = 1'b0,
    PH2 = 1'b1
  } ifpc_phase_t;

  typedef struct packed {
    logic        valid;
    ifpc_op_t    op;
    logic        lock_prefix;
    logic        desc_access;
    logic        mem;
    logic        dir;
    logic        word;
    logic        sext;
    logic [15:0] imm;
    logic        three_comp;
    logic [15:0] offset;
    logic [15:0] limit;
    logic        stack_seg;
    logic        access_ok;
    logic        present;
    logic [1:0]  requested_privilege_level;
    logic [1:0]  descriptor_privilege_level;
    logic        dest_ss;
    logic        to_code;
    logic [15:0] flags_in;
    logic        xfer_io;
    logic        first;
  } ifpc_req_t;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [7:0]  vector;
    logic [15:0] operand;
    logic        to_reg;
    logic        word;
    logic        zf;
  } ifpc_resp_t;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [15:0] addr;
  } ifpc_bus_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } ifpc_wb_req_t;

  typedef struct packed {
    logic       hit;
    logic [7:0] vec;
  } ifpc_fault_t;

endpackage
`default_nettype wire

// [sim/ifpc_check_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ifpc_check_bench;
  logic                   clk;
  logic                   srst;
  ifpc_pkg::ifpc_wb_req_t wbq;
  ifpc_pkg::ifpc_req_t    req;
  ifpc_pkg::ifpc_req_t    r;
  ifpc_pkg::ifpc_resp_t   o_resp;
  ifpc_pkg::ifpc_resp_t   rs;
  ifpc_pkg::ifpc_bus_t    o_bus;
  ifpc_pkg::ifpc_bus_t    bs;
  logic                   o_wb_ack;
  logic                   o_req_ready;
  logic                   o_bus_lock;
  logic                   o_ack;
  logic                   lk;
  logic                   ak;
  logic                   ph;
  logic [31:0]            o_wb_dat;
  logic [31:0]            q;
  int                     mismatches;
  int                     n_compared;
  int                     nf;
  int                     l;
  ifpc_check u_ifpc_check (.i_core_clk(clk), .i_srst(srst), .i_wb(wbq), .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat), .i_req(req), .o_req_ready(o_req_ready), .o_resp(o_resp),
    .o_bus(o_bus), .o_bus_lock(o_bus_lock), .o_coproc_operand_ack(o_ack), .o_proc_phase2(ph));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_resp(input ifpc_pkg::ifpc_resp_t g, input logic [7:0] e);
    chk_data({g.fault, g.vector}, {e != 8'h00, e});
  endtask
  // outputs are flops: read right at the edge, before they update
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wbq <= {1'b1, 1'b1, we, a, 4'hf, d};
    do @(posedge clk); while (o_wb_ack !== 1'b1);
    q = o_wb_dat;
    wbq.cyc <= 1'b0;
    wbq.stb <= 1'b0;
  endtask
  task automatic run(input ifpc_pkg::ifpc_req_t x);
    @(posedge clk);
    req <= x;
    @(posedge clk);
    req.valid <= 1'b0;
    l = 0;
    do begin @(posedge clk); l++; end while (o_resp.valid !== 1'b1 && l < 8);
    rs = o_resp; bs = o_bus; lk = o_bus_lock; ak = o_ack;
    if (rs.fault === 1'b1) nf++;
    chk_data(32'(rs.valid), 32'h1);
  endtask
  task automatic tv(input ifpc_pkg::ifpc_req_t x, input logic [7:0] e);
    run(x);
    chk_resp(rs, e);
  endtask
  function automatic ifpc_pkg::ifpc_req_t mk(input ifpc_pkg::ifpc_op_t op);
    ifpc_pkg::ifpc_req_t x;
    x = '0; x.valid = 1'b1; x.op = op; x.access_ok = 1'b1; x.present = 1'b1;
    x.to_code = 1'b1; x.limit = 16'hffff; x.offset = 16'($urandom_range(0, 32766));
    x.imm = 16'($urandom);
    return x;
  endfunction
  task automatic md(input logic p, input logic [1:0] c);
    wb(1'b1, ifpc_pkg::REG_CTRL, {29'h0, c, p});
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim;
  end
  initial begin
    srst = 1'b1; wbq = '0; req = '0; mismatches = 0; n_compared = 0; nf = 0;
    void'($urandom(32'h450e));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    chk_data(ph, 1'b1);
    tv(mk(ifpc_pkg::OP_PROT_ONLY), 8'h06);
    r = mk(ifpc_pkg::OP_PLAIN); r.mem = 1'b1; r.word = 1'b1; r.offset = 16'hffff;
    tv(r, 8'h0d);
    r = mk(ifpc_pkg::OP_COPROC_XFER); r.limit = 16'h0100; r.offset = 16'h0100; r.word = 1'b1;
    tv(r, 8'h09);
    r = mk(ifpc_pkg::OP_FLAG_LOAD); r.flags_in = 16'h7fff; tv(r, 8'h00);
    wb(1'b0, ifpc_pkg::REG_FLAGS, 32'h0);
    chk_data(q & 32'h7000, 32'h0);
    repeat (8) begin
      r = mk(ifpc_pkg::OP_PLAIN); r.dir = 1'($urandom); r.word = 1'($urandom);
      r.sext = 1'($urandom);
      run(r);
      chk_data({rs.to_reg, rs.word, rs.operand}, {r.dir, r.word, !r.word ? {8'h00, r.imm[7:0]} :
        r.sext ? {{8{r.imm[7]}}, r.imm[7:0]} : r.imm});
    end
    r.three_comp = 1'b1; run(r); chk_data(l, 2);
    $display("real mode tests done");
    md(1'b1, 2'h1);
    tv(mk(ifpc_pkg::OP_PRIV), 8'h0d);
    wb(1'b1, ifpc_pkg::REG_FLAGS, 32'h1000);
    tv(mk(ifpc_pkg::OP_IO), 8'h00);
    md(1'b1, 2'h2);
    tv(mk(ifpc_pkg::OP_IO), 8'h0d);
    r = mk(ifpc_pkg::OP_FLAG_LOAD); r.flags_in = 16'h3200; tv(r, 8'h00);
    wb(1'b0, ifpc_pkg::REG_FLAGS, 32'h0);
    chk_data(q & 32'h3200, 32'h1000);
    r = mk(ifpc_pkg::OP_SEG_LOAD); r.present = 1'b0; r.descriptor_privilege_level = 2'h3; tv(r, 8'h0b);
    r.dest_ss = 1'b1; r.requested_privilege_level = 2'h2; r.descriptor_privilege_level = 2'h2; tv(r, 8'h0c);
    r = mk(ifpc_pkg::OP_SEG_LOAD); r.descriptor_privilege_level = 2'h1; tv(r, 8'h0d);
    r = mk(ifpc_pkg::OP_PLAIN); r.mem = 1'b1; r.stack_seg = 1'b1; r.limit = 16'h0010;
    r.offset = 16'h0020; tv(r, 8'h0c);
    r.stack_seg = 1'b0; r.offset = 16'h0; r.access_ok = 1'b0; tv(r, 8'h0d);
    r = mk(ifpc_pkg::OP_FAR_XFER); r.descriptor_privilege_level = 2'h3; r.limit = 16'h0010; r.offset = 16'h0011;
    tv(r, 8'h0d);
    r = mk(ifpc_pkg::OP_FAR_XFER); tv(r, 8'h0d);
    r = mk(ifpc_pkg::OP_SEL_CHECK); run(r);
    chk_data({rs.fault, rs.zf, rs.operand}, 32'h0);
    r.requested_privilege_level = 2'h2; r.descriptor_privilege_level = 2'h2; run(r); chk_data({rs.fault, rs.zf}, 2'b01);
    r = mk(ifpc_pkg::OP_COPROC_START); r.access_ok = 1'b0; tv(r, 8'h0d);
    r.access_ok = 1'b1; r.stack_seg = 1'b1; r.limit = 16'h0010; r.offset = 16'h0020;
    tv(r, 8'h0c);
    r.op = ifpc_pkg::OP_COPROC_XFER; r.stack_seg = 1'b0; tv(r, 8'h09);
    wb(1'b0, ifpc_pkg::REG_STATUS, 32'h0); chk_data(q, 32'h0000_0109);
    wb(1'b1, ifpc_pkg::REG_STATUS, 32'h0000_0100);
    wb(1'b0, ifpc_pkg::REG_STATUS, 32'h0); chk_data(q, 32'h0000_0009);
    r = mk(ifpc_pkg::OP_COPROC_XFER); r.xfer_io = 1'b1; r.first = 1'b1; run(r);
    chk_data({ak, bs.valid, bs.is_io, bs.addr}, {3'b111, 16'h00fa});
    $display("protected mode tests done");
    repeat (24) begin
      r = mk(ifpc_pkg::ifpc_op_t'(4'($urandom_range(0, 11))));
      r.lock_prefix = 1'($urandom); r.desc_access = 1'($urandom); run(r);
      chk_data(lk, r.lock_prefix | r.desc_access | (r.op == ifpc_pkg::OP_LOCKED));
    end
    wb(1'b0, 8'h10, 32'h0); chk_data(q, 32'h0);
    wb(1'b0, ifpc_pkg::REG_FAULTS, 32'h0); chk_data(q, 32'(nf));
    $display("lock and register tests done");
    end_sim;
  end
endmodule // ifpc_check_bench
`default_nettype wire

// [sim/ifpc_check_props.sv]
`timescale 1ns/1ps
`default_nettype none
module ifpc_check_props (
  input wire logic                 i_core_clk,
  input wire logic                 i_srst,
  input wire ifpc_pkg::ifpc_wb_req_t i_wb,
  input wire logic                 o_wb_ack,
  input wire logic          [31:0] o_wb_dat,
  input wire ifpc_pkg::ifpc_req_t  i_req,
  input wire logic                 o_req_ready,
  input wire ifpc_pkg::ifpc_resp_t o_resp,
  input wire ifpc_pkg::ifpc_bus_t  o_bus,
  input wire logic                 o_bus_lock,
  input wire logic                 o_coproc_operand_ack,
  input wire logic                 o_proc_phase2
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  wire logic tk = i_req.valid & o_req_ready & !i_req.three_comp;
  wire logic tk3 = i_req.valid & o_req_ready & i_req.three_comp;
  wire logic lkq = i_req.lock_prefix | (i_req.op == ifpc_pkg::OP_LOCKED);
  ////////////////////////////////////////////////////////////////////////////
  a_resp_after_take: assert property (tk |=> o_resp.valid)
    else $error("no response one cycle after take");
  a_extra_ea_clock: assert property (tk3 |=>
    !o_req_ready && !o_resp.valid ##1 o_resp.valid)
    else $error("three part offset not one clock longer");
  a_lock_forced: assert property (tk && lkq |=> o_bus_lock)
    else $error("bus lock missing");
  a_lock_with_resp: assert property (o_bus_lock |-> o_resp.valid)
    else $error("bus lock outside response");
  a_ack_first_op: assert property (o_coproc_operand_ack |-> o_bus.valid)
    else $error("operand ack without bus operation");
  a_fault_no_commit: assert property (o_resp.valid && o_resp.fault |->
    o_resp.operand == 16'h0000 && !o_resp.to_reg && !o_bus.valid)
    else $error("faulting request committed");
  a_sel_no_fault: assert property (tk && i_req.op == ifpc_pkg::OP_SEL_CHECK |=>
    !o_resp.fault)
    else $error("selector check raised a fault");
  a_phase_alt: assert property (!$past(i_srst) |->
    o_proc_phase2 != $past(o_proc_phase2))
    else $error("processor phase did not alternate");
  a_phase_reset: assert property (disable iff (1'b0) i_srst |=> o_proc_phase2)
    else $error("reset did not restart phase two");
  a_wb_ack_next: assert property (i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus ack late");
  c_three: cover property (tk3);
  c_fault: cover property (o_resp.valid && o_resp.fault);
  c_ack: cover property (o_coproc_operand_ack);
endmodule // ifpc_check_props
bind ifpc_check ifpc_check_props u_ifpc_check_props (.i_core_clk(i_core_clk), .i_srst(i_srst),
  .i_wb(i_wb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_req(i_req),
  .o_req_ready(o_req_ready), .o_resp(o_resp), .o_bus(o_bus), .o_bus_lock(o_bus_lock),
  .o_coproc_operand_ack(o_coproc_operand_ack), .o_proc_phase2(o_proc_phase2));
`default_nettype wire
